//--- design/pcie_cap_pkg.sv
// Offsets, field layout, defaults and carrier types of the capability register bank
package pcie_cap_pkg;

    // Dword offsets in configuration space
    localparam logic [11:0] OFF_MSI_CTRL = 12'h050;
    localparam logic [11:0] OFF_MSIX_CTRL = 12'h068;
    localparam logic [11:0] OFF_MSIX_TBL = 12'h06c;
    localparam logic [11:0] OFF_MSIX_PBA = 12'h070;
    localparam logic [11:0] OFF_LINK_CAP = 12'h090;
    localparam logic [11:0] OFF_LINK_STAT = 12'h094;
    localparam logic [11:0] OFF_AER_FIRST = 12'h800;
    localparam logic [11:0] OFF_AER_LAST = 12'h834;
    localparam logic [11:0] OFF_AER_CAPCTL = 12'h818;

    // Field positions within the dwords
    localparam int MSI_EN_BIT = 16;
    localparam int MSI_MMC_LSB = 17;
    localparam int MSIX_SIZE_LSB = 16;
    localparam int MSIX_MASK_BIT = 30;
    localparam int MSIX_EN_BIT = 31;
    localparam int PORT_NUM_LSB = 24;
    localparam int SLOT_CLK_BIT = 28;
    localparam int ECRC_GEN_CAP_BIT = 5;
    localparam int ECRC_GEN_EN_BIT = 6;
    localparam int ECRC_CHK_CAP_BIT = 7;
    localparam int ECRC_CHK_EN_BIT = 8;
    localparam int EXT_VER_LSB = 16;

    // Capability identifiers
    localparam logic [7:0] CAP_ID_MSI = 8'h05;
    localparam logic [7:0] CAP_ID_MSIX = 8'h11;
    localparam logic [15:0] EXT_ID_AER = 16'h0001;
    localparam logic [3:0] EXT_VER_AER = 4'h1;

    // Build-time defaults
    localparam logic [7:0] DEF_PORT_NUM = 8'h01;
    localparam logic [4:0] DEF_MSI_MSGS = 5'h01;
    localparam logic [10:0] DEF_MSIX_SIZE = 11'h000;
    localparam logic [31:0] DEF_MSIX_OFFSET = 32'h0000_0000;
    localparam logic [2:0] DEF_BIR = 3'h0;
    localparam logic [2:0] BIR_MAX = 3'h5;

    typedef struct packed {
        logic aer_on;
        logic ecrc_chk_cap;
        logic ecrc_gen_cap;
        logic [7:0] port_num;
        logic slot_clk;
        logic [2:0] msi_mmc;
        logic msix_on;
        logic [10:0] msix_size;
        logic [31:0] tbl_off;
        logic [2:0] tbl_bir;
        logic [31:0] pba_off;
        logic [2:0] pba_bir;
    } build_cfg_t;

    typedef struct packed {
        logic msi_en;
        logic msix_en;
        logic msix_mask;
        logic ecrc_chk_en;
        logic ecrc_gen_en;
    } ctrl_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    localparam ctrl_t CTRL_RESET = '0;

    // Multiple Message Capable code; an illegal count falls back to one message
    function automatic logic [2:0] msi_mmc_code(input logic [4:0] n);
        case (n)
            5'h02: msi_mmc_code = 3'h1;
            5'h04: msi_mmc_code = 3'h2;
            5'h08: msi_mmc_code = 3'h3;
            5'h10: msi_mmc_code = 3'h4;
            default: msi_mmc_code = 3'h0;
        endcase
    endfunction

    // Indicators above five name no BAR, so they collapse to BAR 0
    function automatic logic [2:0] bir_clean(input logic [2:0] b);
        bir_clean = (b > BIR_MAX) ? DEF_BIR : b;
    endfunction

    function automatic logic word_hit(input logic [11:0] addr, input logic [11:0] off);
        word_hit = (addr[11:2] == off[11:2]);
    endfunction

endpackage

//--- design/cfg_readback_mux.sv
// Read data mux of the capability bank: assembles each dword from build config and control state
`timescale 1ns/1ns
module cfg_readback_mux (
    // Lookup
    input wire logic [11:0] addr,
    input wire pcie_cap_pkg::build_cfg_t cfg,
    input wire pcie_cap_pkg::ctrl_t ctrl,
    // Result
    output logic [31:0] rdata
);
    import pcie_cap_pkg::*;

    always_comb begin
        rdata = 32'h0000_0000;
        if (word_hit(addr, OFF_MSI_CTRL)) begin
            rdata[7:0] = CAP_ID_MSI;
            rdata[MSI_EN_BIT] = ctrl.msi_en;
            // [RULE7] message count field
            rdata[MSI_MMC_LSB +: 3] = cfg.msi_mmc;
        end
        // [RULE8] MSI-X only when built
        if (cfg.msix_on) begin
            if (word_hit(addr, OFF_MSIX_CTRL)) begin
                rdata[7:0] = CAP_ID_MSIX;
                // [RULE9] table size, n minus one
                rdata[MSIX_SIZE_LSB +: 11] = cfg.msix_size;
                rdata[MSIX_MASK_BIT] = ctrl.msix_mask;
                rdata[MSIX_EN_BIT] = ctrl.msix_en;
            end
            // [RULE10] offset shares low bits
            if (word_hit(addr, OFF_MSIX_TBL)) begin
                // [RULE11] table BAR indicator
                rdata = {cfg.tbl_off[31:3], cfg.tbl_bir};
            end
            // [RULE12] qword-aligned PBA offset
            if (word_hit(addr, OFF_MSIX_PBA)) begin
                // [RULE13] PBA BAR indicator
                rdata = {cfg.pba_off[31:3], cfg.pba_bir};
            end
        end
        if (word_hit(addr, OFF_LINK_CAP)) begin
            // [RULE5] port number field
            rdata[PORT_NUM_LSB +: 8] = cfg.port_num;
        end
        if (word_hit(addr, OFF_LINK_STAT)) begin
            // [RULE6] slot clock bit
            rdata[SLOT_CLK_BIT] = cfg.slot_clk;
        end
        // [RULE1] AER window present only when built
        if (cfg.aer_on && addr[11:2] >= OFF_AER_FIRST[11:2] && addr[11:2] <= OFF_AER_LAST[11:2]) begin
            if (word_hit(addr, OFF_AER_FIRST)) begin
                rdata[15:0] = EXT_ID_AER;
                rdata[EXT_VER_LSB +: 4] = EXT_VER_AER;
            end
            if (word_hit(addr, OFF_AER_CAPCTL)) begin
                // [RULE2] check-capable bit
                rdata[ECRC_CHK_CAP_BIT] = cfg.ecrc_chk_cap;
                // [RULE3] generation-capable bit
                rdata[ECRC_GEN_CAP_BIT] = cfg.ecrc_gen_cap;
                rdata[ECRC_GEN_EN_BIT] = ctrl.ecrc_gen_en;
                rdata[ECRC_CHK_EN_BIT] = ctrl.ecrc_chk_en;
            end
        end
    end

endmodule // cfg_readback_mux

//--- design/pcie_capability_config_regs.sv
// Capability register bank: build-time AER, link, MSI and MSI-X fields in configuration space
//
// How it works
// [RULE1] AER structure appears at 0x800..0x834 only when the AER option is built.
// [RULE2] ECRC check option sets a read-only check-capable bit in AER control.
// [RULE3] ECRC generation option sets a read-only generation-capable bit in AER control.
// [RULE4] ECRC options take effect only when AER is also built.
// [RULE5] Link capabilities at 0x090 carry a read-only 8-bit port number, default 0x01.
// [RULE6] Slot clock bit reads set for shared reference clock, clear otherwise.
// [RULE7] MSI message count 1,2,4,8,16 loads the Multiple Message Capable field.
// [RULE8] MSI-X capability and fields exist only when MSI-X is built.
// [RULE9] MSI-X table size is 11 bits at 0x068[26:16], count minus one.
// [RULE10] Read-only table offset; low 3 bits hold indicator, forced zero by software.
// [RULE11] Read-only 3-bit table BAR indicator, values zero through five.
// [RULE12] Read-only PBA offset from a BAR, low 3 bits treated zero.
// [RULE13] Read-only 3-bit PBA BAR indicator, values zero through five.
// [RULE14] Writes to build-time fields are ignored; reads return built values.
`timescale 1ns/1ns
module pcie_capability_config_regs #(
    parameter logic AER_ON = 1'b0,
    parameter logic ECRC_CHECK_ON = 1'b0,
    parameter logic ECRC_GEN_ON = 1'b0,
    parameter logic [7:0] PORT_NUM = pcie_cap_pkg::DEF_PORT_NUM,
    parameter logic SLOT_CLK_ON = 1'b0,
    parameter logic [4:0] MSI_MSGS = pcie_cap_pkg::DEF_MSI_MSGS,
    parameter logic MSIX_ON = 1'b0,
    parameter logic [10:0] MSIX_TBL_SIZE = pcie_cap_pkg::DEF_MSIX_SIZE,
    parameter logic [31:0] MSIX_TBL_OFFSET = pcie_cap_pkg::DEF_MSIX_OFFSET,
    parameter logic [2:0] MSIX_TBL_BIR = pcie_cap_pkg::DEF_BIR,
    parameter logic [31:0] MSIX_PBA_OFFSET = pcie_cap_pkg::DEF_MSIX_OFFSET,
    parameter logic [2:0] MSIX_PBA_BIR = pcie_cap_pkg::DEF_BIR
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration access
    input wire pcie_cap_pkg::cfg_req_t cfg_req,
    output logic [31:0] cfg_rdata_ff,
    output logic cfg_rvalid_ff,
    // Software-set controls seen by the rest of the core
    output pcie_cap_pkg::ctrl_t ctrl_ff
);
    import pcie_cap_pkg::*;

    build_cfg_t cfg;
    logic [31:0] nxt_rdata;

    // A write lands on a bit only if its byte lane is enabled
    function automatic logic lane_on(input logic [3:0] be, input int bitpos);
        lane_on = be[bitpos / 8];
    endfunction

    // [RULE4] ECRC capability needs AER
    assign cfg.aer_on = AER_ON;
    assign cfg.ecrc_chk_cap = AER_ON & ECRC_CHECK_ON;
    assign cfg.ecrc_gen_cap = AER_ON & ECRC_GEN_ON;
    assign cfg.port_num = PORT_NUM;
    assign cfg.slot_clk = SLOT_CLK_ON;
    // [RULE7] count to field code
    assign cfg.msi_mmc = msi_mmc_code(MSI_MSGS);
    assign cfg.msix_on = MSIX_ON;
    assign cfg.msix_size = MSIX_TBL_SIZE;
    assign cfg.tbl_off = MSIX_TBL_OFFSET;
    // [RULE11] legal indicator only
    assign cfg.tbl_bir = bir_clean(MSIX_TBL_BIR);
    assign cfg.pba_off = MSIX_PBA_OFFSET;
    // [RULE13] legal indicator only
    assign cfg.pba_bir = bir_clean(MSIX_PBA_BIR);

    cfg_readback_mux u_mux (
        .addr(cfg_req.addr),
        .cfg(cfg),
        .ctrl(ctrl_ff),
        .rdata(nxt_rdata)
    );

    // [RULE14] only enable and mask bits store writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff.msi_en <= CTRL_RESET.msi_en;
        end else if (cfg_req.wr && word_hit(cfg_req.addr, OFF_MSI_CTRL) && lane_on(cfg_req.be, MSI_EN_BIT)) begin
            ctrl_ff.msi_en <= cfg_req.wdata[MSI_EN_BIT];
        end
    end

    // [RULE8] MSI-X controls absent unless built
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff.msix_en <= CTRL_RESET.msix_en;
            ctrl_ff.msix_mask <= CTRL_RESET.msix_mask;
        end else if (MSIX_ON && cfg_req.wr && word_hit(cfg_req.addr, OFF_MSIX_CTRL)) begin
            if (lane_on(cfg_req.be, MSIX_EN_BIT)) begin
                ctrl_ff.msix_en <= cfg_req.wdata[MSIX_EN_BIT];
                ctrl_ff.msix_mask <= cfg_req.wdata[MSIX_MASK_BIT];
            end
        end
    end

    // [RULE4] enables stick only when capable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff.ecrc_chk_en <= CTRL_RESET.ecrc_chk_en;
            ctrl_ff.ecrc_gen_en <= CTRL_RESET.ecrc_gen_en;
        end else if (cfg_req.wr && word_hit(cfg_req.addr, OFF_AER_CAPCTL)) begin
            if (lane_on(cfg_req.be, ECRC_CHK_EN_BIT)) begin
                ctrl_ff.ecrc_chk_en <= cfg.ecrc_chk_cap & cfg_req.wdata[ECRC_CHK_EN_BIT];
            end
            if (lane_on(cfg_req.be, ECRC_GEN_EN_BIT)) begin
                ctrl_ff.ecrc_gen_en <= cfg.ecrc_gen_cap & cfg_req.wdata[ECRC_GEN_EN_BIT];
            end
        end
    end

    // Read data is held until the next read so a slow consumer can still pick it up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_rdata_ff <= 32'h0000_0000;
            cfg_rvalid_ff <= 1'b0;
        end else begin
            cfg_rvalid_ff <= cfg_req.rd;
            if (cfg_req.rd) begin
                // [RULE14] reads return built values
                cfg_rdata_ff <= nxt_rdata;
            end
        end
    end

endmodule // pcie_capability_config_regs

//--- test/pcie_cap_regs_monitor.sv
// Port checks for the capability bank
`timescale 1ns/1ns
module pcie_cap_regs_monitor #(
    parameter logic AER_ON = 1'b0,
    parameter logic ECRC_CHECK_ON = 1'b0,
    parameter logic ECRC_GEN_ON = 1'b0,
    parameter logic [7:0] PORT_NUM = 8'h01,
    parameter logic SLOT_CLK_ON = 1'b0,
    parameter logic [4:0] MSI_MSGS = 5'h01,
    parameter logic MSIX_ON = 1'b0,
    parameter logic [10:0] MSIX_TBL_SIZE = 11'h000
) (
    // Watched ports
    input wire logic clk,
    input wire logic rst,
    input wire pcie_cap_pkg::cfg_req_t cfg_req,
    input wire logic [31:0] cfg_rdata_ff,
    input wire logic cfg_rvalid_ff,
    input wire pcie_cap_pkg::ctrl_t ctrl_ff
);
    import pcie_cap_pkg::*;
    localparam logic [2:0] MMC = (MSI_MSGS == 5'h02) ? 3'h1 : (MSI_MSGS == 5'h04) ? 3'h2 :
        (MSI_MSGS == 5'h08) ? 3'h3 : (MSI_MSGS == 5'h10) ? 3'h4 : 3'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [9:0] wa;
    assign wa = cfg_req.addr[11:2];
    AST_RD_LATENCY: assert property (cfg_req.rd |=> cfg_rvalid_ff)
        else $error("read answer missing");
    AST_NO_SPURIOUS: assert property (!cfg_req.rd |=> !cfg_rvalid_ff)
        else $error("read answer without read");
    AST_RDATA_HOLD: assert property (!cfg_req.rd |=> $stable(cfg_rdata_ff))
        else $error("read data moved without read");
    AST_CTRL_HOLD: assert property (!cfg_req.wr |=> $stable(ctrl_ff))
        else $error("controls moved without write");
    AST_AER_HEADER: assert property (cfg_req.rd && wa == OFF_AER_FIRST[11:2] |=>
        cfg_rdata_ff[15:0] == (AER_ON ? EXT_ID_AER : 16'h0000)) else $error("AER header wrong");
    AST_ECRC_CAPS: assert property (cfg_req.rd && wa == OFF_AER_CAPCTL[11:2] |=>
        cfg_rdata_ff[ECRC_CHK_CAP_BIT] == (AER_ON && ECRC_CHECK_ON) &&
        cfg_rdata_ff[ECRC_GEN_CAP_BIT] == (AER_ON && ECRC_GEN_ON)) else $error("ECRC capable bits wrong");
    AST_ECRC_GATE: assert property (ctrl_ff.ecrc_chk_en |-> AER_ON && ECRC_CHECK_ON)
        else $error("check enable set without capability");
    AST_ECRC_GEN_GATE: assert property (ctrl_ff.ecrc_gen_en |-> AER_ON && ECRC_GEN_ON)
        else $error("generation enable set without capability");
    AST_MSIX_GATE: assert property (ctrl_ff.msix_en || ctrl_ff.msix_mask |-> MSIX_ON)
        else $error("table controls set without table capability");
    AST_PORT_NUM: assert property (cfg_req.rd && wa == OFF_LINK_CAP[11:2] |=>
        cfg_rdata_ff == {PORT_NUM, 24'h000000}) else $error("port number wrong");
    AST_SLOT_CLK: assert property (cfg_req.rd && wa == OFF_LINK_STAT[11:2] |=>
        cfg_rdata_ff[SLOT_CLK_BIT] == SLOT_CLK_ON) else $error("slot clock bit wrong");
    AST_MMC: assert property (cfg_req.rd && wa == OFF_MSI_CTRL[11:2] |=>
        cfg_rdata_ff[MSI_MMC_LSB+:3] == MMC) else $error("message capable code wrong");
    AST_MSIX_SIZE: assert property (cfg_req.rd && wa == OFF_MSIX_CTRL[11:2] |=>
        cfg_rdata_ff[26:16] == (MSIX_ON ? MSIX_TBL_SIZE : 11'h000)) else $error("table size wrong");
    cover property (cfg_req.rd && cfg_req.wr);
    cover property (ctrl_ff.msix_en && ctrl_ff.msix_mask);
    cover property (ctrl_ff.ecrc_chk_en);
endmodule // pcie_cap_regs_monitor

bind pcie_capability_config_regs pcie_cap_regs_monitor #(.AER_ON(AER_ON), .ECRC_CHECK_ON(ECRC_CHECK_ON),
    .ECRC_GEN_ON(ECRC_GEN_ON), .PORT_NUM(PORT_NUM), .SLOT_CLK_ON(SLOT_CLK_ON), .MSI_MSGS(MSI_MSGS),
    .MSIX_ON(MSIX_ON), .MSIX_TBL_SIZE(MSIX_TBL_SIZE)) mon (.clk(clk), .rst(rst), .cfg_req(cfg_req),
    .cfg_rdata_ff(cfg_rdata_ff), .cfg_rvalid_ff(cfg_rvalid_ff), .ctrl_ff(ctrl_ff));

//--- test/pcie_capability_config_regs_tb.sv
// Random self-checking bench for the capability bank
`timescale 1ns/1ns
module pcie_capability_config_regs_tb;
    import pcie_cap_pkg::*;
    localparam logic [7:0] PN = 8'h5a;
    localparam logic [10:0] TSZ = 11'h7ff;
    localparam logic [31:0] TOFF = 32'h1234_567d;
    localparam logic [31:0] POFF = 32'h0abc_def3;
    localparam logic ON = 1'b1;
    localparam logic [4:0] MSGS = 5'h08;
    localparam logic [2:0] TBIR = 3'h2;
    // Deliberately above five, so the PBA indicator must read back as 0
    localparam logic [2:0] PBIR = 3'h6;
    localparam logic [11:0] ADDRS [10] = '{12'h050, 12'h068, 12'h06c, 12'h070, 12'h090, 12'h094,
        12'h800, 12'h818, 12'h834, 12'h0f0};
    logic clk = 1'b0;
    logic rst = 1'b1;
    cfg_req_t req = '0;
    logic [31:0] rdata;
    logic rvalid;
    ctrl_t ctrl;
    logic [31:0] rdata_g [5];
    logic rvalid_g [5];
    ctrl_t ctrl_g [5];
    logic m_msi = 1'b0, m_xen = 1'b0, m_xmask = 1'b0, m_chk = 1'b0, m_gen = 1'b0;
    int miscompares = 0;
    int tests_run = 0;
    always #10 clk = ~clk;
    pcie_capability_config_regs #(.AER_ON(ON), .ECRC_CHECK_ON(ON), .ECRC_GEN_ON(ON), .PORT_NUM(PN),
        .SLOT_CLK_ON(ON), .MSI_MSGS(MSGS), .MSIX_ON(ON), .MSIX_TBL_SIZE(TSZ), .MSIX_TBL_OFFSET(TOFF),
        .MSIX_TBL_BIR(TBIR), .MSIX_PBA_OFFSET(POFF), .MSIX_PBA_BIR(PBIR)) dut (.clk(clk), .rst(rst),
        .cfg_req(req), .cfg_rdata_ff(rdata), .cfg_rvalid_ff(rvalid), .ctrl_ff(ctrl));
    // Bare builds: every mix of ECRC options without AER, no MSI-X, each legal message count
    for (genvar i = 0; i < 5; i++) begin : g_bare
        pcie_capability_config_regs #(.ECRC_CHECK_ON(1'(i % 2)), .ECRC_GEN_ON(1'(i / 2 % 2)),
            .MSI_MSGS(5'(1 << i))) u (
            .clk(clk), .rst(rst), .cfg_req(req), .cfg_rdata_ff(rdata_g[i]), .cfg_rvalid_ff(rvalid_g[i]),
            .ctrl_ff(ctrl_g[i]));
    end
    function automatic logic [31:0] exp_word(input logic [11:0] a, input logic f, input logic [2:0] mmc);
        case ({a[11:2], 2'b00})
            12'h050: exp_word = {12'h000, mmc, m_msi, 16'h0005};
            12'h068: exp_word = f ? {m_xen, m_xmask, 3'h0, TSZ, 16'h0011} : '0;
            12'h06c: exp_word = f ? {TOFF[31:3], TBIR} : '0;
            12'h070: exp_word = f ? {POFF[31:3], 3'h0} : '0;
            12'h090: exp_word = {f ? PN : 8'h01, 24'h000000};
            12'h094: exp_word = {3'h0, f, 28'h0000000};
            12'h800: exp_word = f ? 32'h0001_0001 : '0;
            12'h818: exp_word = f ? {23'h000000, m_chk, 1'b1, m_gen, 1'b1, 5'h00} : '0;
            default: exp_word = '0;
        endcase
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic r, input logic w, input logic [11:0] a, input logic [3:0] be, input logic [31:0] wd);
        logic [31:0] ef;
        logic [31:0] eb [5];
        // Expectations taken before the write: a joint read sees old state
        ef = exp_word(a, 1'b1, 3'h3);
        for (int i = 0; i < 5; i++) begin
            eb[i] = exp_word(a, 1'b0, 3'(i));
        end
        @(posedge clk);
        req <= '{rd: r, wr: w, addr: a, be: be, wdata: wd};
        @(posedge clk);
        req.rd <= 1'b0;
        req.wr <= 1'b0;
        @(negedge clk);
        if (w && a[11:2] == OFF_MSI_CTRL[11:2] && be[2]) m_msi = wd[16];
        if (w && a[11:2] == OFF_MSIX_CTRL[11:2] && be[3]) {m_xen, m_xmask} = wd[31:30];
        if (w && a[11:2] == OFF_AER_CAPCTL[11:2] && be[0]) m_gen = wd[6];
        if (w && a[11:2] == OFF_AER_CAPCTL[11:2] && be[1]) m_chk = wd[8];
        chk("rvalid", 32'(r), 32'(rvalid));
        if (r) chk("rdata", ef, rdata);
        chk("ctrl", {m_msi, m_xen, m_xmask, m_chk, m_gen}, ctrl);
        for (int i = 0; i < 5; i++) begin
            if (r) chk("bare rdata", eb[i], rdata_g[i]);
            chk("bare ctrl", {m_msi, 4'h0}, ctrl_g[i]);
        end
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        end_sim;
    end
    initial begin
        void'($urandom(50));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        acc(1'b1, 1'b1, 12'h818, 4'hf, 32'hffff_ffff);
        acc(1'b1, 1'b1, 12'h06b, 4'h8, 32'hc000_0000);
        acc(1'b1, 1'b1, 12'h090, 4'hf, 32'h0000_0000);
        for (int k = 0; k < 300; k++) begin
            acc(1'($urandom), 1'($urandom), ADDRS[$urandom % 10] | 12'($urandom % 4), 4'($urandom), $urandom);
        end
        end_sim;
    end
endmodule // pcie_capability_config_regs_tb
